/* hdl/pmt_timer.sv */
// Purpose: 8-bit period match timer with prescaler and postscaler
// Assumes: plain register port, read data one cycle after strobe
// Notes: sleep input freezes all counting
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/10ps
module pmt_timer (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // system
    input wire logic sleep,
    // outputs
    output logic period_match_pulse,
    output logic irq
);
    import pmt_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0] timer_count_q, timer_count_d;
    logic [7:0] period_value_q, period_value_d;
    logic [6:0] timer_control_q, timer_control_d;
    logic [3:0] post_q, post_d;
    logic match_irq_flag_q, match_irq_flag_d;
    logic match_irq_enable_q, match_irq_enable_d;
    logic match_pend_q, match_pend_d;
    logic match_d;
    logic irq_d;
    logic [7:0] rdata_d;
    logic tick;
    logic scaler_clear;
    logic wr_count, wr_period, wr_ctl, wr_stat, wr_mask, rd_stat;
    logic timer_on;

    assign wr_count = reg_wr && (reg_addr == PMT_ADDR_COUNT);
    assign wr_period = reg_wr && (reg_addr == PMT_ADDR_PERIOD);
    assign wr_ctl = reg_wr && (reg_addr == PMT_ADDR_CONTROL);
    assign wr_stat = reg_wr && (reg_addr == PMT_ADDR_STATUS);
    assign wr_mask = reg_wr && (reg_addr == PMT_ADDR_MASK);
    assign rd_stat = reg_rd && (reg_addr == PMT_ADDR_STATUS);
    assign scaler_clear = wr_count || wr_ctl;
    assign timer_on = timer_control_q[PMT_CTL_ON_BIT];

    // ----------------------------------------
    // prescaler
    // ----------------------------------------
    pmt_prescale u_pre (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .run(timer_on && !sleep),
        .clear(scaler_clear),
        .sel(timer_control_q[PMT_CTL_PRE_LSB +: 2]),
        .tick(tick)
    );

    // ----------------------------------------
    // counter, compare, postscaler
    // ----------------------------------------
    always_comb begin
        timer_count_d = timer_count_q;
        period_value_d = period_value_q;
        timer_control_d = timer_control_q;
        post_d = post_q;
        match_pend_d = match_pend_q;
        match_irq_flag_d = match_irq_flag_q;
        match_irq_enable_d = match_irq_enable_q;
        match_d = 1'b0;
        // software clear first, so a set in the same cycle below wins
        if (rd_stat || (wr_stat && !reg_wdata[0])) begin
            match_irq_flag_d = 1'b0;
        end
        if (tick && !scaler_clear && !sleep) begin
            if (match_pend_q) begin
                timer_count_d = 8'h00;
                match_pend_d = 1'b0;
            end else begin
                timer_count_d = timer_count_q + 8'h01;
            end
            // compare on the value the tick just produced
            if (timer_count_d == period_value_q) begin
                match_d = 1'b1;
                match_pend_d = 1'b1;
                if (post_q == timer_control_q[PMT_CTL_POST_LSB +: 4]) begin
                    post_d = 4'h0;
                    match_irq_flag_d = 1'b1;
                end else begin
                    post_d = post_q + 4'h1;
                end
            end
        end
        if (wr_count) begin
            timer_count_d = reg_wdata;
            match_pend_d = 1'b0;
        end
        if (wr_period) begin
            period_value_d = reg_wdata;
        end
        if (scaler_clear) begin
            post_d = 4'h0;
        end
        if (wr_ctl) begin
            timer_control_d = reg_wdata[6:0];
        end
        if (wr_mask) begin
            match_irq_enable_d = reg_wdata[0];
        end
        irq_d = match_irq_flag_d && match_irq_enable_d;
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                PMT_ADDR_COUNT: rdata_d = timer_count_q;
                PMT_ADDR_PERIOD: rdata_d = period_value_q;
                PMT_ADDR_CONTROL: rdata_d = {1'b0, timer_control_q};
                PMT_ADDR_STATUS: rdata_d = {7'h00, match_irq_flag_q};
                PMT_ADDR_MASK: rdata_d = {7'h00, match_irq_enable_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            timer_count_q <= PMT_COUNT_RST;
            period_value_q <= PMT_PERIOD_RST;
            timer_control_q <= PMT_CONTROL_RST;
            post_q <= 4'h0;
            match_pend_q <= 1'b0;
            match_irq_flag_q <= 1'b0;
            match_irq_enable_q <= 1'b0;
            period_match_pulse <= 1'b0;
            irq <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            timer_count_q <= timer_count_d;
            period_value_q <= period_value_d;
            timer_control_q <= timer_control_d;
            post_q <= post_d;
            match_pend_q <= match_pend_d;
            match_irq_flag_q <= match_irq_flag_d;
            match_irq_enable_q <= match_irq_enable_d;
            period_match_pulse <= match_d;
            irq <= irq_d;
            reg_rdata <= rdata_d;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_reset_vals;
        @(posedge mclk) $fell(sys_rst) |-> timer_count_q == 8'h00 && period_value_q == 8'hff;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

    property p_pulse_one;
        @(posedge mclk) disable iff (sys_rst) period_match_pulse |=> !period_match_pulse;
    endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("match pulse too long");

    property p_pulse_cause;
        @(posedge mclk) disable iff (sys_rst)
            period_match_pulse |-> timer_count_q == period_value_q;
    endproperty
    a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without equality");

    property p_sleep_hold;
        @(posedge mclk) disable iff (sys_rst)
            sleep && !reg_wr |=> $stable(timer_count_q) && $stable(period_value_q);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("count moved in sleep");

    property p_ctl_keeps;
        @(posedge mclk) disable iff (sys_rst) wr_ctl |=> $stable(timer_count_q);
    endproperty
    a_ctl_keeps: assert property (p_ctl_keeps) else $error("control write changed count");

    property p_irq_gate;
        @(posedge mclk) disable iff (sys_rst)
            irq |-> match_irq_flag_q && match_irq_enable_q;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

    property p_post_clear;
        @(posedge mclk) disable iff (sys_rst) scaler_clear |=> post_q == 4'h0;
    endproperty
    a_post_clear: assert property (p_post_clear) else $error("postscaler not cleared");

    property p_wrap;
        @(posedge mclk) disable iff (sys_rst)
            tick && match_pend_q && !scaler_clear && !sleep |=> timer_count_q == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("count not zeroed after match");

    property p_step;
        @(posedge mclk) disable iff (sys_rst)
            tick && !reg_wr && !sleep && !match_pend_q
            |=> timer_count_q == $past(timer_count_q) + 8'h01;
    endproperty
    a_step: assert property (p_step) else $error("count did not step");

    // ----------------------------------------
    // checks: register port
    // ----------------------------------------
    property p_rst_outputs;
        @(posedge mclk)
            $fell(sys_rst) |-> !period_match_pulse && !irq && reg_rdata == 8'h00;
    endproperty
    a_rst_outputs: assert property (p_rst_outputs) else $error("outputs not idle");

    property p_rdata_idle;
        @(posedge mclk) disable iff (sys_rst)
            !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

    property p_rd_count;
        @(posedge mclk) disable iff (sys_rst)
            reg_rd && reg_addr == PMT_ADDR_COUNT |=> reg_rdata == $past(timer_count_q);
    endproperty
    a_rd_count: assert property (p_rd_count) else $error("bad count read");

    property p_rd_period;
        @(posedge mclk) disable iff (sys_rst)
            reg_rd && reg_addr == PMT_ADDR_PERIOD |=> reg_rdata == $past(period_value_q);
    endproperty
    a_rd_period: assert property (p_rd_period) else $error("bad period read");

    property p_stat_read;
        @(posedge mclk) disable iff (sys_rst)
            rd_stat |=> reg_rdata == {7'h00, $past(match_irq_flag_q)};
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("bad status read");

    property p_wr_count;
        @(posedge mclk) disable iff (sys_rst)
            wr_count |=> timer_count_q == $past(reg_wdata);
    endproperty
    a_wr_count: assert property (p_wr_count) else $error("count write lost");

    property p_wr_period;
        @(posedge mclk) disable iff (sys_rst)
            wr_period |=> period_value_q == $past(reg_wdata);
    endproperty
    a_wr_period: assert property (p_wr_period) else $error("period write lost");

    // ----------------------------------------
    // checks: scalers and flag
    // ----------------------------------------
    property p_pre_clear;
        @(posedge mclk) disable iff (sys_rst)
            scaler_clear |=> !tick;
    endproperty
    a_pre_clear: assert property (p_pre_clear) else $error("tick after scaler clear");

    property p_tick_space;
        @(posedge mclk) disable iff (sys_rst)
            tick |=> !tick [*3];
    endproperty
    a_tick_space: assert property (p_tick_space) else $error("ticks too close");

    property p_pulse_tick;
        @(posedge mclk) disable iff (sys_rst)
            period_match_pulse |-> $past(tick);
    endproperty
    a_pulse_tick: assert property (p_pulse_tick) else $error("pulse without tick");

    property p_sleep_quiet;
        @(posedge mclk) disable iff (sys_rst)
            sleep |=> !period_match_pulse;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("pulse in sleep");

    property p_post_range;
        @(posedge mclk) disable iff (sys_rst)
            post_q <= timer_control_q[PMT_CTL_POST_LSB +: 4];
    endproperty
    a_post_range: assert property (p_post_range) else $error("postscaler overran");

    property p_flag_rise;
        @(posedge mclk) disable iff (sys_rst)
            $rose(match_irq_flag_q) |-> period_match_pulse;
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("flag set without match");

    property p_flag_hold;
        @(posedge mclk) disable iff (sys_rst)
            match_irq_flag_q && !rd_stat && !wr_stat |=> match_irq_flag_q;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

    property p_flag_clear;
        @(posedge mclk) disable iff (sys_rst)
            rd_stat && !match_d |=> !match_irq_flag_q;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_mask_off;
        @(posedge mclk) disable iff (sys_rst)
            wr_mask && !reg_wdata[0] |=> !irq;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("irq while masked");
endmodule : pmt_timer

/* hdl/pmt_pkg.sv */
// Purpose: constants shared by the period match timer
// Assumes: one 20 MHz clock, 8-bit register port
// Notes: offsets are word indices on the plain register port
package pmt_pkg;
    localparam logic [2:0] PMT_ADDR_COUNT = 3'h0;
    localparam logic [2:0] PMT_ADDR_PERIOD = 3'h1;
    localparam logic [2:0] PMT_ADDR_CONTROL = 3'h2;
    localparam logic [2:0] PMT_ADDR_STATUS = 3'h3;
    localparam logic [2:0] PMT_ADDR_MASK = 3'h4;
    // control layout: [6:3] postscale_select, [2] timer_on, [1:0] prescale_select
    localparam int PMT_CTL_PRE_LSB = 0;
    localparam int PMT_CTL_ON_BIT = 2;
    localparam int PMT_CTL_POST_LSB = 3;
    localparam logic [7:0] PMT_COUNT_RST = 8'h00;
    localparam logic [7:0] PMT_PERIOD_RST = 8'hff;
    localparam logic [6:0] PMT_CONTROL_RST = 7'h00;
    localparam logic [1:0] PMT_INSTR_DIV = 2'h3;
    localparam logic [3:0] PMT_PRE_DIV4 = 4'h3;
    localparam logic [3:0] PMT_PRE_DIV16 = 4'hf;
endpackage : pmt_pkg

/* hdl/pmt_prescale.sv */
// Purpose: instruction clock divider and tick prescaler
// Assumes: mclk synchronous, sys_rst active high synchronous
// Notes: emits one-cycle enable pulses, no derived clocks
`timescale 1ns/10ps
module pmt_prescale (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // control
    input wire logic run,
    input wire logic clear,
    input wire logic [1:0] sel,
    // tick out
    output logic tick
);
    import pmt_pkg::*;
    logic [1:0] q_div_q, q_div_d;
    logic [3:0] pre_q, pre_d;
    logic instr_en;
    logic tick_d;

    always_comb begin
        instr_en = run && (q_div_q == PMT_INSTR_DIV);
        q_div_d = q_div_q;
        pre_d = pre_q;
        tick_d = 1'b0;
        if (clear) begin
            pre_d = 4'h0;
        end else if (run) begin
            q_div_d = q_div_q + 2'h1;
            if (instr_en) begin
                unique case (sel)
                    2'b00: tick_d = 1'b1;
                    2'b01: begin
                        tick_d = (pre_q[1:0] == PMT_PRE_DIV4[1:0]);
                        pre_d = pre_q + 4'h1;
                    end
                    default: begin
                        tick_d = (pre_q == PMT_PRE_DIV16);
                        pre_d = pre_q + 4'h1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            q_div_q <= 2'h0;
            pre_q <= 4'h0;
            tick <= 1'b0;
        end else begin
            q_div_q <= q_div_d;
            pre_q <= pre_d;
            tick <= tick_d;
        end
    end
endmodule : pmt_prescale

/* verification/pmt_consumer.sv */
// Purpose: far-side consumer of the period match pulse
// Assumes: pulse used straight on mclk, no resync stage
// Notes: a pulse wider than one cycle latches wide_q
`timescale 1ns/10ps
module pmt_consumer (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // timer output
    input wire logic period_match_pulse,
    // observations
    output logic [15:0] pulse_cnt_q,
    output logic wide_q
);
    logic [15:0] pulse_cnt_d;
    logic wide_d;
    logic last_q;
    always_comb begin
        pulse_cnt_d = pulse_cnt_q + {15'h0000, period_match_pulse};
        // consumer has no synchroniser, so it relies on single-cycle pulses
        wide_d = wide_q | (period_match_pulse & last_q);
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pulse_cnt_q <= 16'h0000;
            wide_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            pulse_cnt_q <= pulse_cnt_d;
            wide_q <= wide_d;
            last_q <= period_match_pulse;
        end
    end
endmodule : pmt_consumer

/* verification/tb_pmt_timer.sv */
// Purpose: self-checking bench for the period match timer
// Assumes: 20 MHz mclk, register port driven by nba after rising edge
// Notes: small random periods keep match gaps short
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_pmt_timer;
    import pmt_pkg::*;
    logic mclk, sys_rst, reg_wr, reg_rd, sleep, period_match_pulse, irq, wide_q;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d, e;
    logic [15:0] pulse_cnt_q;
    logic [31:0] seed_q = 32'ha1cf;
    int n_fail = 0;
    int n_compared = 0;
    int c, k, n, p;
    pmt_timer i_pmt_timer (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sleep(sleep), .period_match_pulse(period_match_pulse), .irq(irq));
    pmt_consumer i_pmt_consumer (.mclk(mclk), .sys_rst(sys_rst),
        .period_match_pulse(period_match_pulse), .pulse_cnt_q(pulse_cnt_q), .wide_q(wide_q));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // instruction clock is mclk/4, then the prescale ratio
    function automatic int exp_gap(input int pv, input int sel);
        return (pv + 1) * 4 * ((sel == 0) ? 1 : ((sel == 1) ? 4 : 16));
    endfunction : exp_gap
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        v = reg_rdata;
    endtask : rd
    task automatic gap(output int cyc);
        cyc = 0;
        do begin
            @(posedge mclk);
            cyc++;
        end while (period_match_pulse !== 1'b1 && cyc < 5000);
    endtask : gap
    task automatic chk_reset();
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), d);
            `CHK(d, (i == 0) ? PMT_COUNT_RST : ((i == 1) ? PMT_PERIOD_RST : 8'h00))
        end
        `CHK(irq, 1'b0)
    endtask : chk_reset
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // longest path is the prescale sweep, well under 60000 cycles
    initial begin
        #3000000;
        n_fail++;
        print_verdict();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        {sys_rst, reg_wr, reg_rd, sleep, reg_addr, reg_wdata} <= {1'b1, 14'h0000};
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        chk_reset();
        for (int i = 0; i < 4; i++) begin
            seed_q = lfsr(seed_q);
            wr(PMT_ADDR_COUNT, seed_q[7:0]);
            wr(PMT_ADDR_PERIOD, seed_q[15:8]);
            wr(3'h5, seed_q[23:16]);
            rd(PMT_ADDR_COUNT, d);
            `CHK(d, seed_q[7:0])
            rd(PMT_ADDR_PERIOD, d);
            `CHK(d, seed_q[15:8])
            rd(3'h5, d);
            `CHK(d, 8'h00)
        end
        wr(PMT_ADDR_CONTROL, 8'h7b);
        rd(PMT_ADDR_COUNT, d);
        `CHK(d, seed_q[7:0])
        rd(PMT_ADDR_CONTROL, d);
        `CHK(d, 8'h7b)
        for (int s = 0; s < 8; s++) begin
            seed_q = lfsr(seed_q);
            p = (s < 4) ? 1 : 2 + seed_q[2:0];
            wr(PMT_ADDR_CONTROL, 8'h00);
            wr(PMT_ADDR_COUNT, 8'h00);
            wr(PMT_ADDR_PERIOD, 8'(p));
            wr(PMT_ADDR_CONTROL, 8'(4 + s % 4));
            n = int'(pulse_cnt_q);
            gap(c);
            gap(c);
            `CHK(c, exp_gap(p, s % 4))
            // let the consumer register the second pulse
            @(posedge mclk);
            `CHK(int'(pulse_cnt_q) - n, 2)
        end
        for (int j = 0; j < 6; j++) begin
            seed_q = lfsr(seed_q);
            n = (j == 0) ? 0 : ((j == 1) ? 15 : seed_q[3:0]);
            wr(PMT_ADDR_CONTROL, 8'h00);
            rd(PMT_ADDR_STATUS, d);
            wr(PMT_ADDR_COUNT, 8'h00);
            wr(PMT_ADDR_PERIOD, 8'h01);
            wr(PMT_ADDR_MASK, 8'h01);
            wr(PMT_ADDR_CONTROL, 8'(n * 8 + 4));
            k = 0;
            for (int i = 0; i < 4000 && irq !== 1'b1; i++) begin
                @(posedge mclk);
                k += int'(period_match_pulse);
            end
            `CHK(k, n + 1)
            `CHK(irq, 1'b1)
            wr(PMT_ADDR_MASK, 8'h00);
            repeat (2) @(posedge mclk);
            `CHK(irq, 1'b0)
            wr(PMT_ADDR_CONTROL, 8'h00);
            rd(PMT_ADDR_STATUS, d);
            `CHK(d, 8'h01)
            rd(PMT_ADDR_STATUS, d);
            `CHK(d, 8'h00)
        end
        wr(PMT_ADDR_PERIOD, 8'hff);
        wr(PMT_ADDR_CONTROL, 8'h04);
        repeat (20) @(posedge mclk);
        sleep <= 1'b1;
        rd(PMT_ADDR_COUNT, d);
        repeat (40) @(posedge mclk);
        rd(PMT_ADDR_COUNT, e);
        `CHK(e, d)
        rd(PMT_ADDR_PERIOD, e);
        `CHK(e, 8'hff)
        // checked before the mid-run reset clears the consumer
        `CHK(wide_q, 1'b0)
        sleep <= 1'b0;
        wr(PMT_ADDR_COUNT, 8'h5a);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        chk_reset();
        print_verdict();
    end
endmodule : tb_pmt_timer
